// ---- include/ssa_defs.vh ----
// constants of the scan shift alignment block: register map, fields, widths
// assumes a 32-bit axi4-lite bus with byte addresses, one register per word
`ifndef SSA_DEFS_VH
`define SSA_DEFS_VH

// bus, byte, counter and position widths
`define SSA_ADDR_W 5
`define SSA_DATA_W 32
`define SSA_BYTE 8
`define SSA_CNT_W 16
`define SSA_POS_W 3

// register byte addresses
`define SSA_OFS_CFG_A 5'h00
`define SSA_OFS_CFG_B 5'h04
`define SSA_OFS_CFG_C 5'h08
`define SSA_OFS_TX 5'h0c
`define SSA_OFS_RX 5'h10
`define SSA_OFS_STAT 5'h14
`define SSA_OFS_CNT 5'h18

// config_reg_a fields
`define SSA_A_TDO_EN 7
`define SSA_A_TDI_EN 6
`define SSA_A_TCK_EN 5
`define SSA_A_LOOP 4
`define SSA_A_MSB 3
// config_reg_b fields
`define SSA_B_TMS_LVL 4
`define SSA_B_TMS_SEL 3
// config_reg_c fields
`define SSA_C_FREE 0

// reset values
`define SSA_RST_CFG 8'h00
`define SSA_RST_CNT 16'h0000
`define SSA_RST_BYTE 8'h00

// alignment counter end of byte
`define SSA_POS_LAST 3'h7
`define SSA_POS_ZERO 3'h0
`define SSA_POS_ONE 3'h1
// returning bit lands this many history stages after its tck pulse
`define SSA_HIST_W 3

// axi responses
`define SSA_RESP_OKAY 2'b00
`define SSA_RESP_SLVERR 2'b10

`endif

// ---- rtl/ssa_sync.v ----
// two-flop synchroniser for one level arriving from outside clk_sys
// assumes the input is a plain level with no timing relation to clk_sys
`timescale 1ns/1ps
module ssa_sync (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // level in and out
    input wire d,
    output reg q
);
    reg meta;

    // first stage feeds only the second stage
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ---- rtl/ssa_shifter.v ----
// one byte-wide serial shifter with parallel load, used for send and receive
// assumes load and shift are never asked in the same cycle by the caller
`timescale 1ns/1ps
`include "ssa_defs.vh"
module ssa_shifter (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // control
    input wire load,
    input wire shift,
    input wire msb_first,
    // data
    input wire [`SSA_BYTE-1:0] load_data,
    input wire serial_in,
    output reg [`SSA_BYTE-1:0] data,
    output wire serial_out
);
    // the bit that leaves first sits at the end it shifts toward
    assign serial_out = msb_first ? data[`SSA_BYTE-1] : data[0];

    // load wins; a shift moves one bit toward the serial end
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data <= `SSA_RST_BYTE;
        end else if (load) begin
            data <= load_data;
        end else if (shift) begin
            if (msb_first) begin
                data <= {data[`SSA_BYTE-2:0], serial_in};
            end else begin
                data <= {serial_in, data[`SSA_BYTE-1:1]};
            end
        end
    end
endmodule

// ---- rtl/ssa_top.v ----
// scan shift alignment: gated test clock, byte-aligned send and receive shifters
// assumes an axi4-lite master on clk_sys and a chain of 1149.1 targets on the pins;
// tdi comes from the chain, outside the clock domain, and is synchronised here
`timescale 1ns/1ps
`include "ssa_defs.vh"

// Notes on behaviour
// R01 - test clock is gated copy of clk_sys
// R02 - tdi sampled on rising clk_sys only
// R03 - shift permit from buffer status and config
// R04 - one three-bit counter keeps bytes aligned
// R05 - mid-byte enable sends only remaining bits
// R06 - software leaves protected config bits while running
// R07 - targets load rising, present falling tck
// R08 - stop tck on full receive, empty send
module ssa_top (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // axi4-lite write address
    input wire [`SSA_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [`SSA_DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`SSA_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [`SSA_DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // scan pins
    output wire tck,
    output reg tdo,
    output reg tms0,
    output reg tms1,
    input wire tdi
);
    // configuration and counters
    reg [`SSA_BYTE-1:0] config_reg_a;
    reg [`SSA_BYTE-1:0] config_reg_b;
    reg [`SSA_BYTE-1:0] config_reg_c;
    reg [`SSA_CNT_W-1:0] shift_count;
    reg [`SSA_POS_W-1:0] bit_pos;
    reg tck_run;
    reg tck_gate;
    // send side
    reg [`SSA_BYTE-1:0] tx_hold;
    reg tx_full;
    reg tx_active;
    // receive side
    reg [`SSA_BYTE-1:0] rx_hold;
    reg rx_full;
    reg [`SSA_HIST_W-1:0] hist_take;
    reg [`SSA_HIST_W-1:0] hist_last;
    // bus state
    reg aw_hold;
    reg w_hold;
    reg [`SSA_ADDR_W-1:0] aw_addr;
    reg [`SSA_DATA_W-1:0] w_data;
    reg [3:0] w_strb;

    wire tdo_en = config_reg_a[`SSA_A_TDO_EN];
    wire tdi_en = config_reg_a[`SSA_A_TDI_EN];
    wire tck_en = config_reg_a[`SSA_A_TCK_EN];
    wire loop_en = config_reg_a[`SSA_A_LOOP];
    wire msb_first = config_reg_a[`SSA_A_MSB];
    wire free_run = config_reg_c[`SSA_C_FREE];

    wire tdi_sync;
    wire [`SSA_BYTE-1:0] tx_data;
    wire [`SSA_BYTE-1:0] rx_data;
    wire tx_bit;

    // R02 tdi synchroniser
    // the pin is only ever sampled by clk_sys; tck never clocks anything here
    ssa_sync u_tdi_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d(tdi),
        .q(tdi_sync)
    );

    // bus handshakes: one write and one read in flight
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire do_write = aw_hold && w_hold && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire wr_tx = do_write && (aw_addr == `SSA_OFS_TX) && w_strb[0];
    wire rd_rx = do_read && (s_axi_araddr == `SSA_OFS_RX);

    // pulse bookkeeping: a pulse is issued in the cycle after tck_run is seen
    wire pulse = tck_run;
    wire last_bit = pulse && (bit_pos == `SSA_POS_LAST);
    wire [`SSA_POS_W-1:0] pos_after = pulse ? bit_pos + `SSA_POS_ONE : bit_pos;
    wire [`SSA_CNT_W-1:0] cnt_after = (pulse && !free_run) ?
        shift_count - {{(`SSA_CNT_W-1){1'b0}}, 1'b1} : shift_count;

    // R05 send shifter reload
    // it loads whenever enabled, idle and tx_full is set, even mid-byte, so only the
    // remaining positions up to the byte boundary get sent
    wire tx_load = tdo_en && !tx_active && tx_full;
    wire tx_active_after = tx_active && !last_bit;

    // R08 receive path idle: nothing in flight and the holding byte read
    wire rx_idle = !rx_full && (hist_take == {`SSA_HIST_W{1'b0}}) &&
        !(pulse && tdi_en);

    // R03 shift permit
    // a byte is only started when each enabled side is ready for a whole byte;
    // inside a byte the buffers are not checked; only run enable and the count matter
    reg next_tck_run;
    always @* begin
        next_tck_run = 1'b0;
        if (tck_en && (free_run || cnt_after != {`SSA_CNT_W{1'b0}})) begin
            if (pos_after != `SSA_POS_ZERO) begin
                next_tck_run = 1'b1;
            end else begin
                // R08 no start on empty send or full receive
                next_tck_run = (!tdo_en || tx_active_after) && (!tdi_en || rx_idle);
            end
        end
    end

    // run flag and alignment counter
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tck_run <= 1'b0;
            bit_pos <= `SSA_POS_ZERO;
            shift_count <= `SSA_RST_CNT;
        end else begin
            tck_run <= next_tck_run;
            // R04 single byte counter
            bit_pos <= pos_after;
            if (do_write && aw_addr == `SSA_OFS_CNT) begin
                // software writes win; the count is not expected to move mid-run
                shift_count[7:0] <= w_strb[0] ? w_data[7:0] : cnt_after[7:0];
                shift_count[15:8] <= w_strb[1] ? w_data[15:8] : cnt_after[15:8];
            end else begin
                shift_count <= cnt_after;
            end
        end
    end

    // R01 glitch-free gate
    // the enable changes only while clk_sys is low, so tck pulses are whole
    always @(negedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tck_gate <= 1'b0;
        end else begin
            tck_gate <= tck_run;
        end
    end

    // R01 gated test clock
    assign tck = clk_sys & tck_gate;

    // send holding byte; a new load from the bus beats the transfer out
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_hold <= `SSA_RST_BYTE;
            tx_full <= 1'b0;
        end else begin
            if (wr_tx) begin
                tx_hold <= w_data[`SSA_BYTE-1:0];
            end
            if (wr_tx) begin
                tx_full <= 1'b1;
            end else if (tx_load) begin
                tx_full <= 1'b0;
            end
        end
    end

    // send shifter state
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_active <= 1'b0;
        end else if (tx_load) begin
            tx_active <= 1'b1;
        end else if (last_bit) begin
            tx_active <= 1'b0;
        end
    end

    ssa_shifter u_tx (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(tx_load),
        .shift(pulse && tx_active),
        .msb_first(msb_first),
        .load_data(tx_hold),
        .serial_in(1'b0),
        .data(tx_data),
        .serial_out(tx_bit)
    );

    // R07 tdo timing
    // targets sample on the rising tck edge; tdo moves on the same clk_sys
    // edge through the flop, so the old bit is what the target takes
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tdo <= 1'b0;
        end else if (loop_en) begin
            tdo <= tdi_sync;
        end else if (tx_load) begin
            tdo <= msb_first ? tx_hold[`SSA_BYTE-1] : tx_hold[0];
        end else if (pulse && tx_active && !last_bit) begin
            tdo <= msb_first ? tx_data[`SSA_BYTE-2] : tx_data[1];
        end else if (!tx_active || last_bit) begin
            tdo <= 1'b0;
        end
    end

    // R07 return alignment
    // targets present on the falling edge of the pulse; the bit then takes
    // the sampling edge plus two sync stages, so it lands three stages late
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hist_take <= {`SSA_HIST_W{1'b0}};
            hist_last <= {`SSA_HIST_W{1'b0}};
        end else begin
            hist_take <= {hist_take[`SSA_HIST_W-2:0], pulse && tdi_en};
            hist_last <= {hist_last[`SSA_HIST_W-2:0], last_bit};
        end
    end

    wire rx_take = hist_take[`SSA_HIST_W-1];
    wire rx_done = rx_take && hist_last[`SSA_HIST_W-1];

    ssa_shifter u_rx (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(1'b0),
        .shift(rx_take),
        .msb_first(msb_first),
        .load_data(`SSA_RST_BYTE),
        .serial_in(tdi_sync),
        .data(rx_data),
        .serial_out()
    );

    // receive holding byte; a completing byte beats a read that clears it
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_hold <= `SSA_RST_BYTE;
            rx_full <= 1'b0;
        end else if (rx_done) begin
            rx_hold <= msb_first ? {rx_data[`SSA_BYTE-2:0], tdi_sync} :
                {tdi_sync, rx_data[`SSA_BYTE-1:1]};
            rx_full <= 1'b1;
        end else if (rd_rx) begin
            rx_full <= 1'b0;
        end
    end

    // tms levels follow config_reg_b; the unselected chain is held low
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tms0 <= 1'b0;
            tms1 <= 1'b0;
        end else begin
            tms0 <= !config_reg_b[`SSA_B_TMS_SEL] && config_reg_b[`SSA_B_TMS_LVL];
            tms1 <= config_reg_b[`SSA_B_TMS_SEL] && config_reg_b[`SSA_B_TMS_LVL];
        end
    end

    // write channel capture; address and data may come in either order
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= {`SSA_ADDR_W{1'b0}};
            w_data <= {`SSA_DATA_W{1'b0}};
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold <= 1'b0;
            end
        end
    end

    // R06 config writes
    // writes are taken as given; changing the protected fields mid-run
    // would break byte alignment, and software is trusted not to
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            config_reg_a <= `SSA_RST_CFG;
            config_reg_b <= `SSA_RST_CFG;
            config_reg_c <= `SSA_RST_CFG;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr == `SSA_OFS_CFG_A) begin
                config_reg_a <= w_data[`SSA_BYTE-1:0];
            end
            if (aw_addr == `SSA_OFS_CFG_B) begin
                config_reg_b <= w_data[`SSA_BYTE-1:0];
            end
            if (aw_addr == `SSA_OFS_CFG_C) begin
                config_reg_c <= w_data[`SSA_BYTE-1:0];
            end
        end
    end

    // write decode: the status and receive words are read only
    wire wr_mapped = (aw_addr == `SSA_OFS_CFG_A) || (aw_addr == `SSA_OFS_CFG_B) ||
        (aw_addr == `SSA_OFS_CFG_C) || (aw_addr == `SSA_OFS_TX) ||
        (aw_addr == `SSA_OFS_CNT);

    // write response
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SSA_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `SSA_RESP_OKAY : `SSA_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read mux; unmapped words read zero with an error response
    reg [`SSA_DATA_W-1:0] rd_word;
    reg rd_ok;
    always @* begin
        rd_word = {`SSA_DATA_W{1'b0}};
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `SSA_OFS_CFG_A: rd_word[`SSA_BYTE-1:0] = config_reg_a;
            `SSA_OFS_CFG_B: rd_word[`SSA_BYTE-1:0] = config_reg_b;
            `SSA_OFS_CFG_C: rd_word[`SSA_BYTE-1:0] = config_reg_c;
            `SSA_OFS_TX: rd_word[`SSA_BYTE-1:0] = tx_hold;
            `SSA_OFS_RX: rd_word[`SSA_BYTE-1:0] = rx_hold;
            `SSA_OFS_STAT: rd_word[`SSA_BYTE-1:0] = {tck_run, tx_active, tx_full,
                rx_full, 1'b0, bit_pos};
            `SSA_OFS_CNT: rd_word[`SSA_CNT_W-1:0] = shift_count;
            default: rd_ok = 1'b0;
        endcase
    end

    // read response
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= {`SSA_DATA_W{1'b0}};
            s_axi_rresp <= `SSA_RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `SSA_RESP_OKAY : `SSA_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ---- testbench/ssa_top_asserts.sv ----
// checker for scan shift alignment: bus answers and quiet pin levels
// assumes it is bound to ssa_top and sees only that module's ports
`timescale 1ns/1ps
`include "ssa_defs.vh"
module ssa_top_asserts (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // write channels
    input wire [`SSA_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [`SSA_DATA_W-1:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // read channels
    input wire [`SSA_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [`SSA_DATA_W-1:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    // scan pins
    input wire tck,
    input wire tdo
);
    reg [`SSA_ADDR_W-1:0] aw_q;
    reg [7:0] w_q;
    reg [7:0] cfg_a;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // shadow of config_reg_a; it lags the design, so just after a write it still shows the old enables
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            aw_q <= `SSA_OFS_CFG_A;
            w_q <= `SSA_RST_CFG;
            cfg_a <= `SSA_RST_CFG;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                w_q <= s_axi_wdata[7:0];
            if (s_axi_bvalid && s_axi_bready && aw_q == `SSA_OFS_CFG_A)
                cfg_a <= w_q;
        end
    end
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence resp_after;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    // sampled at the rising edge, tck shows its clk_sys-low level
    a_tck_gated: assert property (!tck)
        else $error("tck high while clk_sys low");
    a_write_answer: assert property (wr_taken |=> resp_after)
        else $error("write response not two cycles after request");
    a_write_ro: assert property (wr_taken ##0 (s_axi_awaddr == `SSA_OFS_RX
        || s_axi_awaddr == `SSA_OFS_STAT) |=> ##1 s_axi_bresp == `SSA_RESP_SLVERR)
        else $error("read-only write not refused");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_read_unmapped: assert property (rd_taken ##0 s_axi_araddr > `SSA_OFS_CNT
        |=> s_axi_rresp == `SSA_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_tdo_quiet: assert property ((!cfg_a[`SSA_A_TDO_EN] && !cfg_a[`SSA_A_LOOP]) [*2]
        |-> !tdo)
        else $error("tdo driven with sending off");
endmodule
bind ssa_top ssa_top_asserts ssa_top_asserts_i (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .tck(tck), .tdo(tdo)
);

// ---- testbench/ssa_chain_model.sv ----
// scan chain stand-in: one target of len cells between tdo and tdi
// assumes tck rests low between pulses; cells take preset during reset
`timescale 1ns/1ps
module ssa_chain_model #(parameter LEN = 8) (
    // reset and preset
    input wire rstn,
    input wire [LEN-1:0] preset,
    // scan pins
    input wire tck,
    input wire tdo,
    output reg tdi,
    // bits taken from tdo, newest in bit 0
    output reg [31:0] hist
);
    reg [LEN-1:0] cells;
    reg cap;
    always @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            cap <= 1'b0;
            hist <= 32'h0;
        end else begin
            cap <= tdo;
            hist <= {hist[30:0], tdo};
        end
    end
    always @(negedge tck or negedge rstn) begin
        if (!rstn) begin
            cells <= preset;
            tdi <= preset[LEN-1];
        end else begin
            tdi <= cells[LEN-1];
            cells <= {cells[LEN-2:0], cap};
        end
    end
endmodule

// ---- testbench/ssa_top_tb.sv ----
// self-checking bench for ssa_top against a one-target scan chain model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`include "ssa_defs.vh"
module ssa_top_tb;
    reg clk_sys = 1'b0;
    reg rstn = 1'b1;
    reg [4:0] awaddr = 5'h00;
    reg [4:0] araddr = 5'h00;
    reg [31:0] wdata = 32'h0;
    reg [3:0] wstrb = 4'hf;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    reg [7:0] preset = 8'h00;
    wire awready, wready, bvalid, arready, rvalid, tck, tdo, tms0, tms1, tdi;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, hist;
    integer errors = 0;
    integer total_checks = 0;
    integer seed = 68824;
    integer pulses = 0;
    real t_rise = 0.0;
    reg [31:0] rv;
    reg [1:0] rs;
    reg [7:0] x, y, z;
    reg [4:0] a;
    ssa_top ssa_top_i (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .tck(tck), .tdo(tdo), .tms0(tms0), .tms1(tms1), .tdi(tdi));
    ssa_chain_model ssa_chain_model_i (.rstn(rstn), .preset(preset), .tck(tck),
        .tdo(tdo), .tdi(tdi), .hist(hist));
    // 20 mhz system clock
    always #25 clk_sys = ~clk_sys;
    task check(input bit ok, input string msg);
        total_checks = total_checks + 1;
        if (!ok) begin
            errors = errors + 1;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // every tck pulse must be one whole clk_sys high phase
    always @(posedge tck) begin
        pulses = pulses + 1;
        t_rise = $realtime;
    end
    always @(negedge tck) begin
        check($realtime - t_rise == 25.0, "tck pulse width");
    end
    // preset is updated before rstn in the same step, so the chain takes the new value;
    // reset falls at time zero on the first call, before any edge meets unknown state
    task do_reset;
        preset <= $random(seed);
        rstn <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        pulses = 0;
    endtask
    // both write channels offered together, each released once taken
    task wr(input [4:0] ad, input [31:0] d);
        bit aw_ok, w_ok;
        @(posedge clk_sys);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 0;
        w_ok = 0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys);
            if (awvalid && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge clk_sys);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task rd(input [4:0] ad);
        @(posedge clk_sys);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge clk_sys);
        while (!arready) @(posedge clk_sys);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk_sys);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // read status until the masked bits match
    task poll(input [7:0] m, input [7:0] v);
        rd(`SSA_OFS_STAT);
        while ((rv[7:0] & m) !== v) rd(`SSA_OFS_STAT);
    endtask
    // a hang costs a mismatch and ends the run the usual way
    initial begin
        #(20000 * 50);
        errors = errors + 1;
        wrap_up;
    end
    initial begin
        do_reset;
        // reset values, then refusals of an unmapped word and the read-only status word
        for (a = 5'h00; a < 5'h1c; a = a + 5'h04) begin
            rd(a);
            check(rv === 32'h0 && rs === `SSA_RESP_OKAY, "reset value");
        end
        rd(5'h1c);
        check(rs === `SSA_RESP_SLVERR && rv === 32'h0, "unmapped read");
        wr(`SSA_OFS_STAT, 32'hff);
        check(rs === `SSA_RESP_SLVERR, "status write");
        // tms routing, changed only while the test clock is stopped
        wr(`SSA_OFS_CFG_B, 32'h18);
        @(posedge clk_sys);
        check(tms1 === 1'b1 && tms0 === 1'b0, "tms routed to chain one");
        // mid-byte enable: stop at position three, then send five bits
        wr(`SSA_OFS_CFG_A, 32'h28);
        wr(`SSA_OFS_CNT, 32'h3);
        poll(8'h80, 8'h00);
        check(pulses === 3 && rv[2:0] === 3'h3, "stop at position three");
        z = $random(seed);
        wr(`SSA_OFS_CFG_A, 32'ha8);
        wr(`SSA_OFS_TX, {24'h0, z});
        wr(`SSA_OFS_CNT, 32'h5);
        poll(8'h80, 8'h00);
        check(pulses === 8 && rv[2:0] === 3'h0, "byte end realigned");
        check(hist[4:0] === z[7:3], "partial byte bits");
        // round trip with receive stall, after a reset with the test clock stopped
        do_reset;
        x = $random(seed);
        y = $random(seed);
        wr(`SSA_OFS_CFG_A, 32'he8);
        wr(`SSA_OFS_TX, {24'h0, x});
        wr(`SSA_OFS_CNT, 32'h18);
        poll(8'h20, 8'h00);
        wr(`SSA_OFS_TX, {24'h0, y});
        poll(8'h90, 8'h10);
        check(pulses === 8, "stall on full receive");
        rd(`SSA_OFS_RX);
        check(rv === {24'h0, preset}, "first received byte");
        poll(8'h90, 8'h10);
        rd(`SSA_OFS_RX);
        check(rv === {24'h0, x} && pulses === 16, "second received byte");
        poll(8'h80, 8'h00);
        rd(`SSA_OFS_CNT);
        check(pulses === 16 && rv === 32'h8, "stop on empty send");
        wrap_up;
    end
endmodule
